// >>> design/srd_dev.sv
// How it works
// - Board leaves select pin open or pulls up
// - Fixed delay chosen by variant and pin
// - Timing capacitor at least 250 pF
// - Capacitor delay set by charge to trip
// - Capacitor delay kept between minimum and maximum
// - Asserted reset discharges the timing capacitor
// - Conditions clear: charge, release at trip
// - Grounded select pin selects latch mode
// - Latch mode holds reset low after fault
// - Pin above trip unlatches reset at once
// - Unlatch drive above 1.2 V via resistor
// - Power up latched; far end pulses pin
// - Glitch filter length follows overdrive amplitude
// - Reclassify select pin on window re-entry
// - Manual reset low asserts, release after delay
// - Supply lockout holds reset low
// - Sense outside threshold asserts reset
`timescale 1ns/100ps
`default_nettype none
`include "srd_map.svh"

module srd_dev #(
  parameter int unsigned     VARIANT      = 0,
  parameter int unsigned     DLY_OPEN_CYC =
    srd_pkg::srd_open_us(VARIANT) * (`SRD_CLK_KHZ / 1000),
  parameter int unsigned     DLY_PULL_CYC =
    srd_pkg::srd_pull_us(VARIANT) * (`SRD_CLK_KHZ / 1000),
  parameter int unsigned     CLASSIFY_CYC =
    `SRD_CLASSIFY_US * (`SRD_CLK_KHZ / 1000),
  parameter longint unsigned CAP_PF       = `SRD_CAP_DEF_PF,
  parameter longint unsigned CAP_MIN_CYC  = srd_pkg::srd_cap_min_cyc(CAP_PF),
  parameter longint unsigned CAP_MAX_CYC  = srd_pkg::srd_cap_max_cyc(CAP_PF)
) (
  input  wire logic          CLK_I,
  input  wire logic          RST_I,
  srd_link_if.dev            LINK,
  output logic               RESET_ACTIVE_O,
  output logic               CLASSIFYING_O,
  output logic               SENSE_FAULT_O,
  output srd_pkg::srd_mode_e MODE_O
);
  import srd_pkg::*;

  // ------------------------------------------------------------------
  // Timing constants
  // ------------------------------------------------------------------
  localparam srd_cnt_t PROBE_CYC =
    srd_cnt_t'(`SRD_FLOAT_PROBE_US * (`SRD_CLK_KHZ / 1000));
  localparam srd_cnt_t CLS_LAST  = srd_cnt_t'(CLASSIFY_CYC - 1);
  localparam srd_cnt_t CLS_HALF  = srd_cnt_t'(CLASSIFY_CYC / 2);
  localparam srd_cnt_t OPEN_LAST = srd_cnt_t'(DLY_OPEN_CYC - 1);
  localparam srd_cnt_t PULL_LAST = srd_cnt_t'(DLY_PULL_CYC - 1);
  localparam srd_cnt_t CAP_MIN   = srd_cnt_t'(CAP_MIN_CYC);
  localparam srd_cnt_t CAP_LAST  = srd_cnt_t'(CAP_MAX_CYC - 1);

  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  if (VARIANT >= `SRD_VARIANTS) begin : g_bad_variant
    $error("srd_dev: VARIANT out of range");
  end
  if (CAP_PF < `SRD_CAP_MIN_PF) begin : g_bad_cap
    $error("srd_dev: CAP_PF below the least timing capacitor");
  end
  if (DLY_OPEN_CYC < 1 || DLY_PULL_CYC < 1) begin : g_bad_dly
    $error("srd_dev: fixed delays must be at least one cycle");
  end
  if (CLASSIFY_CYC < 2 * PROBE_CYC + 2) begin : g_bad_cls
    $error("srd_dev: CLASSIFY_CYC too short for the pin probe");
  end
  if (CAP_MAX_CYC < CAP_MIN_CYC || CAP_MAX_CYC > 64'hffffffff) begin : g_bad_cw
    $error("srd_dev: capacitor window not served by the counter");
  end

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  srd_dev_s  r_reg;
  srd_dev_s  r_next;
  srd_in_t   raw;
  srd_gcnt_t glen;
  logic      clear;
  logic      trip;
  logic      lockout;
  logic      done;
  srd_mode_e found;

  // Input bits: 0 sense over, 2:1 overdrive, 3 lockout, 4 manual reset,
  // 5 pin trip, 6 pin grounded
  assign raw = {LINK.dsel_grounded, LINK.dsel_trip, LINK.manual_reset_n_in,
                LINK.supply_lockout, LINK.overdrive, LINK.sense_over};

  always_comb begin
    r_next = r_reg;
    glen   = `SRD_GLITCH_OD0;
    found  = SRD_OPEN;
    done   = 1'b0;

    // ----------------------------------------------------------------
    // Pin synchronisers: a change counts once stages two and three agree
    // ----------------------------------------------------------------
    r_next.s1 = raw;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    for (int i = 0; i < $bits(srd_in_t); i++) begin
      if (r_reg.s2[i] == r_reg.s3[i]) begin
        r_next.flt[i] = r_reg.s3[i];
      end
    end

    // ----------------------------------------------------------------
    // Sense glitch filter: larger overdrive trips sooner
    // ----------------------------------------------------------------
    case (r_reg.flt[2:1])
      2'h0:    glen = `SRD_GLITCH_OD0;
      2'h1:    glen = `SRD_GLITCH_OD1;
      2'h2:    glen = `SRD_GLITCH_OD2;
      default: glen = `SRD_GLITCH_OD3;
    endcase
    if (!r_reg.flt[0]) begin
      r_next.gcnt = '0;
      r_next.over = 1'b0;
    end else if (r_reg.gcnt >= glen - 16'h0001) begin
      r_next.over = 1'b1;
    end else begin
      r_next.gcnt = r_reg.gcnt + 16'h0001;
    end

    lockout = r_reg.flt[3];
    trip    = r_reg.flt[5];
    // All reset causes gone
    clear   = !lockout && r_reg.flt[4] && !r_reg.over;

    // A fault marks the pin for a fresh look on window re-entry
    if (r_reg.over) begin
      r_next.need_cls = 1'b1;
    end

    // Pin option from the probe results
    if (r_reg.pull_seen) begin
      found = SRD_PULL;
    end else if (r_reg.open_seen) begin
      found = SRD_OPEN;
    end else if (r_reg.flt[6]) begin
      found = SRD_LATCHED;
    end else if (VARIANT == `SRD_CAP_VARIANT) begin
      found = SRD_OPEN;
    end else begin
      found = SRD_CAP;
    end

    // Release decision for the timed phase
    case (r_reg.mode)
      SRD_PULL: done = (r_reg.cnt >= PULL_LAST);
      SRD_CAP:  done = (trip && r_reg.cnt >= CAP_MIN)
                       || (r_reg.cnt >= CAP_LAST);
      default:  done = (r_reg.cnt >= OPEN_LAST);
    endcase

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    case (r_reg.st)
      SRD_HOLD: begin
        r_next.cnt = '0;
        if (clear) begin
          if (r_reg.need_cls) begin
            r_next.st        = SRD_CLASS;
            r_next.pull_seen = 1'b0;
            r_next.open_seen = 1'b0;
          end else if (r_reg.mode == SRD_LATCHED) begin
            r_next.st = SRD_LATCH;
          end else begin
            r_next.st = SRD_DELAY;
          end
        end
      end
      SRD_CLASS: begin
        if (!clear) begin
          r_next.st  = SRD_HOLD;
          r_next.cnt = '0;
        end else begin
          r_next.cnt = r_reg.cnt + 32'h1;
          // First half: pulldown on, a high pin means a pull-up
          if (r_reg.cnt < CLS_HALF) begin
            if (trip) begin
              r_next.pull_seen = 1'b1;
            end
          // Second half: charge on, a fast rise means an open pin
          end else if (trip && r_reg.cnt < CLS_HALF + PROBE_CYC) begin
            r_next.open_seen = 1'b1;
          end
          if (r_reg.cnt >= CLS_LAST) begin
            r_next.cnt      = '0;
            r_next.need_cls = 1'b0;
            r_next.mode     = found;
            r_next.st       = (found == SRD_LATCHED) ? SRD_LATCH : SRD_DELAY;
          end
        end
      end
      SRD_DELAY: begin
        if (!clear) begin
          r_next.st = SRD_HOLD;
        end else if (done) begin
          r_next.st = SRD_RUN;
        end else begin
          r_next.cnt = r_reg.cnt + 32'h1;
        end
      end
      SRD_RUN: begin
        if (!clear) begin
          r_next.st = SRD_HOLD;
        end
      end
      SRD_LATCH: begin
        if (lockout) begin
          r_next.st = SRD_HOLD;
        end else if (trip) begin
          r_next.st = SRD_RUN;
        end
      end
      default: begin
        r_next.st = SRD_HOLD;
      end
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      r_reg          <= '0;
      // Stages start at the idle levels, so no false manual reset follows
      r_reg.s1       <= 7'h10;
      r_reg.s2       <= 7'h10;
      r_reg.s3       <= 7'h10;
      r_reg.flt      <= 7'h10;
      r_reg.need_cls <= 1'b1;
      r_reg.mode     <= SRD_OPEN;
      r_reg.st       <= SRD_HOLD;
    end else begin
      r_reg <= r_next;
    end
  end

  // ------------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------------
  assign LINK.rst_n_oe       = (r_reg.st != SRD_RUN);
  // Capacitor held empty while reset is asserted and not charging
  assign LINK.dsel_dis       = (r_reg.st == SRD_HOLD)
                            || (r_reg.st == SRD_LATCH)
                            || (r_reg.st == SRD_CLASS && r_reg.cnt < CLS_HALF)
                            || (r_reg.st == SRD_DELAY
                                && r_reg.mode != SRD_CAP);
  assign LINK.charge_current = (r_reg.st == SRD_CLASS && r_reg.cnt >= CLS_HALF)
                            || (r_reg.st == SRD_DELAY
                                && r_reg.mode == SRD_CAP);

  assign RESET_ACTIVE_O = (r_reg.st != SRD_RUN);
  assign CLASSIFYING_O  = (r_reg.st == SRD_CLASS);
  assign SENSE_FAULT_O  = r_reg.over;
  assign MODE_O         = r_reg.mode;

endmodule : srd_dev

`default_nettype wire

// >>> design/srd_map.svh
`ifndef SRD_MAP_SVH
`define SRD_MAP_SVH

// ------------------------------------------------------------------
// Clock
// ------------------------------------------------------------------
`define SRD_CLK_KHZ          50000

// ------------------------------------------------------------------
// Pin classification timing
// ------------------------------------------------------------------
`define SRD_CLASSIFY_US      450
`define SRD_FLOAT_PROBE_US   20

// ------------------------------------------------------------------
// Fixed release delays per variant, in microseconds
// ------------------------------------------------------------------
`define SRD_VARIANTS         4
`define SRD_DLY_OPEN_US_V0   10000
`define SRD_DLY_OPEN_US_V1   1000
`define SRD_DLY_OPEN_US_V2   5000
`define SRD_DLY_OPEN_US_V3   50
`define SRD_DLY_PULL_US_V0   200000
`define SRD_DLY_PULL_US_V1   20000
`define SRD_DLY_PULL_US_V2   100000
`define SRD_DLY_PULL_US_V3   50
`define SRD_CAP_VARIANT      3

// ------------------------------------------------------------------
// Capacitor mode bounds: slope in 1e-4 ms/nF, offset in 0.1 ms
// ------------------------------------------------------------------
`define SRD_CAP_TYP_SLOPE    30660
`define SRD_CAP_MIN_SLOPE    27427
`define SRD_CAP_MAX_SLOPE    34636
`define SRD_CAP_SLOPE_DIV    10000000
`define SRD_CAP_MIN_OFS_DMS  3
`define SRD_CAP_MAX_OFS_DMS  7
`define SRD_CAP_OFS_DIV      10
`define SRD_CAP_MIN_PF       250
`define SRD_CAP_DEF_PF       1000

// ------------------------------------------------------------------
// Sense glitch filter length per overdrive class, in cycles
// ------------------------------------------------------------------
`define SRD_GLITCH_OD0       16'h0100
`define SRD_GLITCH_OD1       16'h0040
`define SRD_GLITCH_OD2       16'h0010
`define SRD_GLITCH_OD3       16'h0004

// ------------------------------------------------------------------
// Far end timing, in cycles
// ------------------------------------------------------------------
`define SRD_STARTUP_CYC      100
`define SRD_UNLATCH_CYC      50

`endif

// >>> design/srd_pkg.sv
`default_nettype none

package srd_pkg;
`include "srd_map.svh"

  typedef logic [31:0] srd_cnt_t;
  typedef logic [15:0] srd_gcnt_t;
  typedef logic [6:0]  srd_in_t;

  typedef enum logic [2:0] {
    SRD_HOLD, SRD_CLASS, SRD_DELAY, SRD_RUN, SRD_LATCH
  } srd_state_e;

  typedef enum logic [1:0] {
    SRD_OPEN, SRD_PULL, SRD_CAP, SRD_LATCHED
  } srd_mode_e;

  typedef enum logic [1:0] {
    SRDH_WAIT, SRDH_IDLE, SRDH_PULSE
  } srd_host_e;

  typedef struct packed {
    srd_in_t    s1;
    srd_in_t    s2;
    srd_in_t    s3;
    srd_in_t    flt;
    srd_gcnt_t  gcnt;
    logic       over;
    logic       need_cls;
    logic       pull_seen;
    logic       open_seen;
    srd_mode_e  mode;
    srd_state_e st;
    srd_cnt_t   cnt;
  } srd_dev_s;

  typedef struct packed {
    logic      s1;
    logic      s2;
    logic      s3;
    logic      flt;
    logic      man;
    srd_host_e st;
    srd_cnt_t  cnt;
  } srd_host_s;

  function automatic int unsigned srd_open_us(input int unsigned v);
    case (v)
      0:       return `SRD_DLY_OPEN_US_V0;
      1:       return `SRD_DLY_OPEN_US_V1;
      2:       return `SRD_DLY_OPEN_US_V2;
      default: return `SRD_DLY_OPEN_US_V3;
    endcase
  endfunction : srd_open_us

  function automatic int unsigned srd_pull_us(input int unsigned v);
    case (v)
      0:       return `SRD_DLY_PULL_US_V0;
      1:       return `SRD_DLY_PULL_US_V1;
      2:       return `SRD_DLY_PULL_US_V2;
      default: return `SRD_DLY_PULL_US_V3;
    endcase
  endfunction : srd_pull_us

  // Least delay, rounded up to whole cycles
  function automatic longint unsigned srd_cap_min_cyc(input longint unsigned pf);
    longint unsigned a;
    longint unsigned b;
    a = `SRD_CAP_MIN_SLOPE * pf * `SRD_CLK_KHZ;
    b = `SRD_CAP_MIN_OFS_DMS * `SRD_CLK_KHZ;
    return (a + `SRD_CAP_SLOPE_DIV - 1) / `SRD_CAP_SLOPE_DIV
         + (b + `SRD_CAP_OFS_DIV - 1) / `SRD_CAP_OFS_DIV;
  endfunction : srd_cap_min_cyc

  // Longest delay, rounded down to whole cycles
  function automatic longint unsigned srd_cap_max_cyc(input longint unsigned pf);
    longint unsigned a;
    longint unsigned b;
    a = `SRD_CAP_MAX_SLOPE * pf * `SRD_CLK_KHZ;
    b = `SRD_CAP_MAX_OFS_DMS * `SRD_CLK_KHZ;
    return a / `SRD_CAP_SLOPE_DIV + b / `SRD_CAP_OFS_DIV;
  endfunction : srd_cap_max_cyc

endpackage : srd_pkg

`default_nettype wire

// >>> design/srd_link_if.sv
`timescale 1ns/100ps
`default_nettype none

interface srd_link_if;
  // Reset output, open drain, pulled up on the board
  logic       rst_n_oe;
  logic       rst_n;
  // Manual reset input, internally pulled up
  logic       man_rst_n_o;
  logic       man_rst_n_oe;
  logic       manual_reset_n_in;
  // Delay select pin: far end drive, device pulldown and charge current
  logic       dsel_o;
  logic       dsel_oe;
  logic       dsel_dis;
  logic       charge_current;
  // Analog front end results, given by the bench
  logic       dsel_trip;
  logic       dsel_grounded;
  logic       sense_over;
  logic [1:0] overdrive;
  logic       supply_lockout;

  assign rst_n             = ~rst_n_oe;
  assign manual_reset_n_in = man_rst_n_oe ? man_rst_n_o : 1'b1;

  modport dev (
    input  manual_reset_n_in, dsel_trip, dsel_grounded, sense_over,
    input  overdrive, supply_lockout,
    output rst_n_oe, dsel_dis, charge_current
  );

  modport host (
    input  rst_n,
    output man_rst_n_o, man_rst_n_oe, dsel_o, dsel_oe
  );
endinterface : srd_link_if

`default_nettype wire

// >>> design/srd_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "srd_map.svh"

module srd_host #(
  parameter int unsigned STARTUP_CYC  = `SRD_STARTUP_CYC,
  parameter int unsigned UNLATCH_CYC  = `SRD_UNLATCH_CYC,
  parameter bit          AUTO_UNLATCH = 1'b1
) (
  input  wire logic CLK_I,
  input  wire logic RST_I,
  srd_link_if.host  LINK,
  input  wire logic MAN_REQ_I,
  input  wire logic UNLATCH_REQ_I,
  output logic      RESET_N_O,
  output logic      BUSY_O
);
  import srd_pkg::*;

  localparam srd_cnt_t START_LAST = srd_cnt_t'(STARTUP_CYC - 1);
  localparam srd_cnt_t PULSE_LAST = srd_cnt_t'(UNLATCH_CYC - 1);

  if (STARTUP_CYC < 1 || UNLATCH_CYC < 1) begin : g_bad_cnt
    $error("srd_host: counts must be at least one cycle");
  end

  srd_host_s r_reg;
  srd_host_s r_next;

  always_comb begin
    r_next    = r_reg;
    r_next.s1 = LINK.rst_n;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    if (r_reg.s2 == r_reg.s3) begin
      r_next.flt = r_reg.s3;
    end
    r_next.man = MAN_REQ_I;
    case (r_reg.st)
      // Wait out the startup delay before the first unlatch pulse
      SRDH_WAIT: begin
        r_next.cnt = r_reg.cnt + 32'h1;
        if (r_reg.cnt >= START_LAST) begin
          r_next.cnt = '0;
          r_next.st  = AUTO_UNLATCH ? SRDH_PULSE : SRDH_IDLE;
        end
      end
      SRDH_IDLE: begin
        if (UNLATCH_REQ_I) begin
          r_next.cnt = '0;
          r_next.st  = SRDH_PULSE;
        end
      end
      SRDH_PULSE: begin
        r_next.cnt = r_reg.cnt + 32'h1;
        if (r_reg.cnt >= PULSE_LAST) begin
          r_next.cnt = '0;
          r_next.st  = SRDH_IDLE;
        end
      end
      default: begin
        r_next.st = SRDH_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      r_reg     <= '0;
      r_reg.st  <= SRDH_WAIT;
    end else begin
      r_reg <= r_next;
    end
  end

  // Pin driven high through the series resistor only during a pulse,
  // and left open for the factory delays otherwise
  assign LINK.dsel_o       = 1'b1;
  assign LINK.dsel_oe      = (r_reg.st == SRDH_PULSE);
  assign LINK.man_rst_n_o  = 1'b0;
  assign LINK.man_rst_n_oe = r_reg.man;
  assign RESET_N_O         = r_reg.flt;
  assign BUSY_O            = (r_reg.st != SRDH_IDLE);

endmodule : srd_host

`default_nettype wire

// >>> tb/srd_link_checker.sv
`timescale 1ns/100ps
`default_nettype none

module srd_link_checker #(
  parameter int unsigned CLASSIFY_CYC = 2100,
  parameter int unsigned MIN_DLY_CYC  = 30
) (
  input wire logic       CLK_I,
  input wire logic       RST_I,
  input wire logic       rst_n_oe,
  input wire logic       manual_reset_n_in,
  input wire logic       dsel_oe,
  input wire logic       dsel_dis,
  input wire logic       charge_current,
  input wire logic       dsel_trip,
  input wire logic       dsel_grounded,
  input wire logic       sense_over,
  input wire logic [1:0] overdrive,
  input wire logic       supply_lockout
);
  localparam int unsigned LATCH_CNT = CLASSIFY_CYC + 100;

  logic [15:0] clr_reg;
  logic [15:0] grd_reg;
  logic [15:0] ovr_reg;
  logic        calm;

  // ------------------------------------------------------------------
  // Cycle counters of quiet inputs, grounded pin and slow overdrive
  // ------------------------------------------------------------------
  assign calm = manual_reset_n_in && !sense_over && !supply_lockout;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      clr_reg <= 16'h0;
      grd_reg <= 16'h0;
      ovr_reg <= 16'h0;
    end else begin
      clr_reg <= calm ? clr_reg + 16'h1 : 16'h0;
      grd_reg <= (calm && dsel_grounded) ? grd_reg + 16'h1 : 16'h0;
      ovr_reg <= (sense_over && overdrive == 2'h0) ? ovr_reg + 16'h1 : 16'h0;
    end
  end

  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  lockout_hold_a: assert property (
    supply_lockout [*6] |-> rst_n_oe) else $error("released in lockout");
  manual_hold_a: assert property (
    (!manual_reset_n_in) [*6] |-> rst_n_oe)
    else $error("released in manual reset");
  fault_fast_a: assert property (
    (sense_over && overdrive == 2'h3) [*8] |-> ##[0:4] rst_n_oe)
    else $error("large overdrive not answered");
  slow_fault_a: assert property (
    ovr_reg == 16'd270 |-> rst_n_oe) else $error("small overdrive missed");
  glitch_ignore_a: assert property (
    (calm && !rst_n_oe) [*8] ##1 (sense_over && manual_reset_n_in &&
    !supply_lockout) ##1 calm [*8] |-> !rst_n_oe)
    else $error("spike caused reset");
  latch_hold_a: assert property (
    (dsel_grounded && !dsel_trip) [*6] ##0 rst_n_oe |=> rst_n_oe)
    else $error("latched reset released");
  unlatch_fast_a: assert property (
    grd_reg >= LATCH_CNT && $rose(dsel_trip) |-> ##[1:8] !rst_n_oe)
    else $error("unlatch too slow");
  early_release_a: assert property (
    $fell(rst_n_oe) && !dsel_oe |-> clr_reg >= MIN_DLY_CYC)
    else $error("release before delay");
  discharge_a: assert property (
    rst_n_oe && !charge_current && !dsel_grounded && !dsel_oe |-> dsel_dis)
    else $error("capacitor not discharged");
  charge_held_a: assert property (
    charge_current |-> rst_n_oe) else $error("charging while released");
endmodule : srd_link_checker

`default_nettype wire

// >>> tb/supervisor_reset_delay_latch_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "srd_map.svh"

module supervisor_reset_delay_latch_tb;
  import srd_pkg::*;
  localparam int CLS = 2100;
  localparam int DOPEN = 50;
  localparam int DPULL = 100;
  localparam int CMIN = 30;
  localparam int CMAX = 60;

  logic        clk;
  logic        rst;
  logic        man_req;
  logic        unl_req;
  logic [1:0]  cfg;
  logic        cap_fast;
  logic [15:0] cap_cnt = 16'd0;
  logic        rst_act;
  logic        cls;
  logic        sfault;
  logic        host_rst_n;
  logic        busy;
  srd_mode_e   mode;
  int          bad_count;
  int          n_compared;
  int          cyc = 0;
  int          od;
  int          n;
  int          glen [4] = '{`SRD_GLITCH_OD0, `SRD_GLITCH_OD1,
                            `SRD_GLITCH_OD2, `SRD_GLITCH_OD3};

  srd_link_if link();

  // ------------------------------------------------------------------
  // Select pin model: 0 open, 1 pulled up, 2 grounded, 3 capacitor
  // ------------------------------------------------------------------
  assign link.dsel_trip = (link.dsel_oe & link.dsel_o) | (cfg == 2'd1)
    | (cfg == 2'd0 & link.charge_current)
    | (cfg == 2'd3 & cap_cnt >= (cap_fast ? 16'd40 : 16'd4000));
  assign link.dsel_grounded = (cfg == 2'd2)
    & ~(link.dsel_oe & link.dsel_o);

  always @(posedge clk) begin
    cap_cnt <= (link.charge_current && !cls) ? cap_cnt + 16'd1 : 16'd0;
  end

  srd_dev #(.VARIANT(0), .DLY_OPEN_CYC(DOPEN), .DLY_PULL_CYC(DPULL),
    .CLASSIFY_CYC(CLS), .CAP_MIN_CYC(CMIN), .CAP_MAX_CYC(CMAX)) i_srd_dev (
    .CLK_I(clk), .RST_I(rst), .LINK(link), .RESET_ACTIVE_O(rst_act),
    .CLASSIFYING_O(cls), .SENSE_FAULT_O(sfault), .MODE_O(mode));

  srd_host #(.AUTO_UNLATCH(1'b0)) i_srd_host (
    .CLK_I(clk), .RST_I(rst), .LINK(link), .MAN_REQ_I(man_req),
    .UNLATCH_REQ_I(unl_req), .RESET_N_O(host_rst_n), .BUSY_O(busy));

  srd_link_checker #(.CLASSIFY_CYC(CLS), .MIN_DLY_CYC(CMIN))
    i_srd_link_checker (
    .CLK_I(clk), .RST_I(rst), .rst_n_oe(link.rst_n_oe),
    .manual_reset_n_in(link.manual_reset_n_in), .dsel_oe(link.dsel_oe),
    .dsel_dis(link.dsel_dis), .charge_current(link.charge_current),
    .dsel_trip(link.dsel_trip), .dsel_grounded(link.dsel_grounded),
    .sense_over(link.sense_over), .overdrive(link.overdrive),
    .supply_lockout(link.supply_lockout));

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask : chk

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic fault;
    link.sense_over = 1'b1;
    tick(30);
    link.sense_over = 1'b0;
  endtask : fault

  // Cycles from end of classification (or from call) to release
  task automatic expect_release(input srd_mode_e m, input int lo,
                                input int hi);
    int c;
    int k;
    c = 0;
    for (k = 0; k < 6000 && link.rst_n !== 1'b1; k++) begin
      c = (cls === 1'b1) ? 0 : c + 1;
      tick(1);
    end
    chk(mode === m, "classified mode");
    chk(c >= lo && c <= hi, "release delay");
    tick(5);
    chk(rst_act === 1'b0 && host_rst_n === 1'b1, "seen released");
  endtask : expect_release

  task automatic unlatch;
    chk(busy === 1'b0, "host busy");
    unl_req = 1'b1;
    tick(1);
    unl_req = 1'b0;
    n = 0;
    while (link.rst_n !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    chk(n <= 8, "unlatch release");
    tick(60);
  endtask : unlatch

  // ------------------------------------------------------------------
  // Clock, timeout and test sequence
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      $display("FAIL %0t timeout", $time);
      stop_test();
    end
  end

  initial begin
    rst = 1'b1;
    man_req = 1'b0;
    unl_req = 1'b0;
    cfg = 2'd0;
    cap_fast = 1'b1;
    bad_count = 0;
    n_compared = 0;
    link.sense_over = 1'b0;
    link.overdrive = 2'd3;
    link.supply_lockout = 1'b0;
    tick(20);
    chk(link.rst_n === 1'b0 && link.dsel_dis === 1'b1, "held in reset");
    rst = 1'b0;
    expect_release(SRD_OPEN, DOPEN - 1, DOPEN + 2);
    link.sense_over = 1'b1;
    tick(1);
    link.sense_over = 1'b0;
    tick(30);
    chk(link.rst_n === 1'b1, "spike caused reset");
    for (od = 3; od >= 0; od--) begin
      link.overdrive = od[1:0];
      link.sense_over = 1'b1;
      n = 0;
      while (link.rst_n === 1'b1 && n < 400) begin
        tick(1);
        n++;
      end
      chk(n >= glen[od] && n <= glen[od] + 8, "fault response");
      chk(sfault === 1'b1 && link.dsel_dis === 1'b1, "fault state");
      tick(10);
      chk(host_rst_n === 1'b0, "host sees reset");
      link.sense_over = 1'b0;
      expect_release(SRD_OPEN, DOPEN - 1, DOPEN + 2);
    end
    link.overdrive = 2'd3;
    man_req = 1'b1;
    tick(10);
    chk(link.rst_n === 1'b0, "manual reset held");
    man_req = 1'b0;
    expect_release(SRD_OPEN, DOPEN, DOPEN + 10);
    link.supply_lockout = 1'b1;
    tick(100);
    chk(link.rst_n === 1'b0, "lockout hold");
    link.supply_lockout = 1'b0;
    expect_release(SRD_OPEN, DOPEN - 1, DOPEN + 10);
    cfg = 2'd1;
    fault();
    expect_release(SRD_PULL, DPULL - 1, DPULL + 2);
    cfg = 2'd3;
    fault();
    expect_release(SRD_CAP, 40, CMAX - 1);
    cap_fast = 1'b0;
    fault();
    expect_release(SRD_CAP, CMAX - 1, CMAX + 2);
    cfg = 2'd2;
    fault();
    tick(CLS + 300);
    chk(link.rst_n === 1'b0 && mode === SRD_LATCHED, "latched");
    unlatch();
    fault();
    tick(CLS + 300);
    chk(link.rst_n === 1'b0, "relatched after fault");
    unlatch();
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    unl_req = 1'b1;
    tick(1);
    unl_req = 1'b0;
    tick(3);
    chk(link.dsel_oe === 1'b0, "unlatch during startup");
    tick(CLS + 300);
    chk(link.rst_n === 1'b0, "latched at power up");
    unlatch();
    stop_test();
  end
endmodule : supervisor_reset_delay_latch_tb

`default_nettype wire
